/* design/tlcf_defines.svh */
// constants of the two-level capability flow filter
// assumes nothing; included by the package and the design modules
`ifndef TLCF_DEFINES_SVH
`define TLCF_DEFINES_SVH
// ========================================
// permission bitfield layout; scope flag and new permissions placed here
`define TLCF_PW 9
`define TLCF_P_R 0
`define TLCF_P_W 1
`define TLCF_P_C 2
`define TLCF_P_LM 3
`define TLCF_P_X 4
`define TLCF_P_ASR 5
`define TLCF_P_SL 6
`define TLCF_P_LG 7
`define TLCF_P_GL 8
`define TLCF_TYPEW 4
`define TLCF_ADDRW 32
// ========================================
// root capability permissions
`define TLCF_ROOT_EXEC_PERMS 9'h1bd
`define TLCF_ROOT_DATA_PERMS 9'h1ef
// ========================================
// register offsets and reset values
`define TLCF_REG_CTRL 4'h0
`define TLCF_REG_STRIPS 4'h4
`define TLCF_REG_ATTENS 4'h8
`define TLCF_REG_LASTOP 4'hc
`define TLCF_CTRL_RESET 1'h1
`endif

/* design/tlcf_pkg.sv */
// types shared by the capability flow filter modules
// assumes the defines header is on the include path
package tlcf_pkg;
`include "tlcf_defines.svh"
  typedef struct packed {
    logic tag;
    logic [`TLCF_TYPEW-1:0] otype;
    logic [`TLCF_PW-1:0] perms;
    logic [`TLCF_ADDRW-1:0] addr;
  } tlcf_cap_t;

  typedef enum logic [3:0] {
    TLCF_OP_LOAD = 4'h1,
    TLCF_OP_STORE = 4'h2,
    TLCF_OP_PCLR = 4'h3,
    TLCF_OP_PREAD = 4'h4,
    TLCF_OP_SUBSET = 4'h5,
    TLCF_OP_BUILD = 4'h6,
    TLCF_OP_SUNSEAL = 4'h7,
    TLCF_OP_ROOTX = 4'h8,
    TLCF_OP_ROOTD = 4'h9
  } tlcf_op_t;

  // clear refinements whose prerequisites are gone
  function automatic logic [`TLCF_PW-1:0] tlcf_fix_deps(input logic [`TLCF_PW-1:0] p);
    logic [`TLCF_PW-1:0] q;
    q = p;
    if (!(p[`TLCF_P_C] && p[`TLCF_P_R])) q[`TLCF_P_LG] = 1'b0;
    if (!(p[`TLCF_P_C] && p[`TLCF_P_W])) q[`TLCF_P_SL] = 1'b0;
    return q;
  endfunction
endpackage

/* design/tlcf_cap_if.sv */
// interface between the top and one capability filter
// assumes the package is compiled first
`timescale 1ns/1ns
interface tlcf_cap_if;
  import tlcf_pkg::*;
  logic en;
  tlcf_cap_t auth;
  tlcf_cap_t data;
  tlcf_cap_t res;
  logic hit;
  modport filt(input en, input auth, input data, output res, output hit);
  modport user(output en, output auth, output data, input res, input hit);
endinterface

/* design/tlcf_store_filter.sv */
// combinational filter for capabilities written to memory
// assumes the caller registers its result
`timescale 1ns/1ns
module tlcf_store_filter (
  tlcf_cap_if.filt f
);
  import tlcf_pkg::*;
  `include "tlcf_defines.svh"
  logic refine;
  // refinement only counts when the authority may write capabilities at all
  assign refine = f.en && f.auth.perms[`TLCF_P_C] && f.auth.perms[`TLCF_P_W];
  // local value through an authority without store-local loses its tag
  assign f.hit = refine && !f.auth.perms[`TLCF_P_SL] && f.data.tag &&
    !f.data.perms[`TLCF_P_GL];
  always_comb begin
    f.res = f.data;
    if (f.hit) begin
      f.res.tag = 1'b0;
    end
  end
endmodule // tlcf_store_filter

/* design/tlcf_load_filter.sv */
// combinational filter for capabilities read from memory
// assumes the caller registers its result
`timescale 1ns/1ns
module tlcf_load_filter (
  tlcf_cap_if.filt f
);
  import tlcf_pkg::*;
  `include "tlcf_defines.svh"
  logic refine;
  logic sealed;
  assign refine = f.en && f.auth.perms[`TLCF_P_C] && f.auth.perms[`TLCF_P_R];
  assign sealed = f.data.otype != '0;
  assign f.hit = refine && f.data.tag && !f.auth.perms[`TLCF_P_LG];
  // implicit clear: the scope flag goes even on sealed values
  always_comb begin
    f.res = f.data;
    if (f.hit) begin
      f.res.perms[`TLCF_P_GL] = 1'b0;
      if (!sealed) begin
        f.res.perms[`TLCF_P_LG] = 1'b0;
      end
    end
    // base load-mutable attenuation drops write, so store-local goes too
    if (refine && f.data.tag && !sealed && !f.auth.perms[`TLCF_P_LM]) begin
      f.res.perms[`TLCF_P_W] = 1'b0;
      f.res.perms[`TLCF_P_LM] = 1'b0;
      f.res.perms = tlcf_fix_deps(f.res.perms);
    end
  end
endmodule // tlcf_load_filter

/* design/tlcf_top.sv */
// two-level capability flow filter: load/store filtering and capability ops
// assumes requests come from logic on the same clock, one per cycle at most
// Functional notes
// - store local via non-store-local authority clears tag
// - store-local counts only with transfer and store-data
// - unsealed load without load-wide clears flag, permission
// - sealed load without load-wide clears flag only
// - load-wide counts only with transfer and load-data
// - one scope bit, 1 wide, 0 local
// - derivation clears scope flag, never sets it
// - permission clear drops scope flag even sealed
// - dependent permissions cleared with their prerequisites
// - load-mutable attenuation also clears store-local
// - subset needs second local or first wide
// - build tag needs template local or authority wide
// - sentry unseal scope is AND of both flags
// - roots are wide with their required permissions
// - scope and new permissions sit in permission field
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "tlcf_defines.svh"
module tlcf_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic op_valid,
  input wire tlcf_pkg::tlcf_op_t op_code,
  input wire tlcf_pkg::tlcf_cap_t op_auth,
  input wire tlcf_pkg::tlcf_cap_t op_data,
  input wire logic [`TLCF_PW-1:0] op_mask,
  output logic res_valid,
  output tlcf_pkg::tlcf_cap_t res_cap,
  output logic [31:0] res_word
);
  import tlcf_pkg::*;

  // ========================================
  // filter instances
  tlcf_cap_if st_if();
  tlcf_cap_if ld_if();
  logic levels_en;
  assign st_if.en = levels_en;
  assign st_if.auth = op_auth;
  assign st_if.data = op_data;
  assign ld_if.en = levels_en;
  assign ld_if.auth = op_auth;
  assign ld_if.data = op_data;

  tlcf_store_filter u_store (
    .f(st_if.filt)
  );

  tlcf_load_filter u_load (
    .f(ld_if.filt)
  );

  // ========================================
  // operation datapath
  tlcf_cap_t next_cap;
  logic [31:0] next_word;
  logic a_sealed;
  logic b_sealed;
  logic perm_sub;
  logic [`TLCF_PW-1:0] clr_mask;
  assign a_sealed = op_auth.otype != '0;
  assign b_sealed = op_data.otype != '0;
  // scope bit lives in the permission field, so plain subset covers it
  assign perm_sub = (op_data.perms & ~op_auth.perms) == '0;

  always_comb begin
    next_cap = op_data;
    next_word = 32'h0;
    clr_mask = op_mask;
    case (op_code)
      TLCF_OP_LOAD: begin
        next_cap = ld_if.res;
      end
      TLCF_OP_STORE: begin
        next_cap = st_if.res;
      end
      TLCF_OP_PCLR: begin
        // sealed values may only lose the scope flag
        if (b_sealed) begin
          clr_mask = op_mask & (`TLCF_PW'(1) << `TLCF_P_GL);
        end
        next_cap.perms = tlcf_fix_deps(op_data.perms & ~clr_mask);
        if (b_sealed) begin
          next_cap.perms = op_data.perms & ~clr_mask;
        end
      end
      TLCF_OP_PREAD: begin
        next_word = {{(32 - `TLCF_PW){1'b0}}, op_data.perms};
      end
      TLCF_OP_SUBSET: begin
        // first operand is op_data, second is op_auth
        next_word = {31'h0, perm_sub && op_data.tag == op_auth.tag &&
          (!op_auth.perms[`TLCF_P_GL] || op_data.perms[`TLCF_P_GL])};
      end
      TLCF_OP_BUILD: begin
        // a wide template needs a wide authority, else no tag
        next_cap.tag = op_auth.tag && !a_sealed && perm_sub &&
          (!op_data.perms[`TLCF_P_GL] || op_auth.perms[`TLCF_P_GL]);
      end
      TLCF_OP_SUNSEAL: begin
        next_cap.otype = '0;
        next_cap.tag = op_data.tag && op_auth.tag;
        next_cap.perms[`TLCF_P_GL] = op_data.perms[`TLCF_P_GL] &&
          op_auth.perms[`TLCF_P_GL];
      end
      TLCF_OP_ROOTX: begin
        next_cap = '0;
        next_cap.tag = 1'b1;
        next_cap.perms = `TLCF_ROOT_EXEC_PERMS;
      end
      TLCF_OP_ROOTD: begin
        next_cap = '0;
        next_cap.tag = 1'b1;
        next_cap.perms = `TLCF_ROOT_DATA_PERMS;
      end
      default: begin
        next_cap = op_data;
      end
    endcase
  end

  // ========================================
  // result registers
  tlcf_op_t res_op;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_cap <= '0;
      res_word <= 32'h0;
      res_op <= TLCF_OP_LOAD;
    end else begin
      res_valid <= op_valid;
      if (op_valid) begin
        res_cap <= next_cap;
        res_word <= next_word;
        res_op <= op_code;
      end
    end
  end

  // ========================================
  // software registers
  logic [15:0] strips;
  logic [15:0] attens;
  // control: bit 0 enables both flow filters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      levels_en <= `TLCF_CTRL_RESET;
    end else if (reg_wr && reg_addr == `TLCF_REG_CTRL) begin
      levels_en <= reg_wdata[0];
    end
  end

  // event counters: a write clears, an event in that cycle still counts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strips <= 16'h0;
    end else if (op_valid && op_code == TLCF_OP_STORE && st_if.hit) begin
      strips <= (reg_wr && reg_addr == `TLCF_REG_STRIPS) ? 16'h1 : strips + 16'h1;
    end else if (reg_wr && reg_addr == `TLCF_REG_STRIPS) begin
      strips <= 16'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      attens <= 16'h0;
    end else if (op_valid && op_code == TLCF_OP_LOAD && ld_if.hit) begin
      attens <= (reg_wr && reg_addr == `TLCF_REG_ATTENS) ? 16'h1 : attens + 16'h1;
    end else if (reg_wr && reg_addr == `TLCF_REG_ATTENS) begin
      attens <= 16'h0;
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else if (reg_addr == `TLCF_REG_CTRL) begin
      reg_rdata <= {31'h0, levels_en};
    end else if (reg_addr == `TLCF_REG_STRIPS) begin
      reg_rdata <= {16'h0, strips};
    end else if (reg_addr == `TLCF_REG_ATTENS) begin
      reg_rdata <= {16'h0, attens};
    end else if (reg_addr == `TLCF_REG_LASTOP) begin
      reg_rdata <= {28'h0, res_op};
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_store_strip;
    op_valid && op_code == TLCF_OP_STORE && levels_en && op_auth.perms[`TLCF_P_C] &&
      op_auth.perms[`TLCF_P_W] && !op_auth.perms[`TLCF_P_SL] && op_data.tag &&
      !op_data.perms[`TLCF_P_GL] |=> res_valid && !res_cap.tag;
  endproperty
  a_store_strip: assert property (p_store_strip) else $error("local store kept tag");

  property p_store_pass;
    op_valid && op_code == TLCF_OP_STORE && !(op_auth.perms[`TLCF_P_C] &&
      op_auth.perms[`TLCF_P_W]) |=> res_cap == $past(op_data);
  endproperty
  a_store_pass: assert property (p_store_pass) else $error("store altered");

  property p_load_unsealed;
    op_valid && op_code == TLCF_OP_LOAD && levels_en && op_auth.perms[`TLCF_P_C] &&
      op_auth.perms[`TLCF_P_R] && !op_auth.perms[`TLCF_P_LG] && op_data.tag &&
      !b_sealed |=> !res_cap.perms[`TLCF_P_GL] && !res_cap.perms[`TLCF_P_LG];
  endproperty
  a_load_unsealed: assert property (p_load_unsealed) else $error("load kept scope");

  property p_load_sealed;
    op_valid && op_code == TLCF_OP_LOAD && levels_en && op_auth.perms[`TLCF_P_C] &&
      op_auth.perms[`TLCF_P_R] && !op_auth.perms[`TLCF_P_LG] && op_data.tag &&
      b_sealed |=> !res_cap.perms[`TLCF_P_GL] &&
      res_cap.perms[`TLCF_P_GL-1:0] == $past(op_data.perms[`TLCF_P_GL-1:0]);
  endproperty
  a_load_sealed: assert property (p_load_sealed) else $error("sealed load wrong");

  property p_load_pass;
    op_valid && op_code == TLCF_OP_LOAD && !(op_auth.perms[`TLCF_P_C] &&
      op_auth.perms[`TLCF_P_R]) |=> res_cap == $past(op_data);
  endproperty
  a_load_pass: assert property (p_load_pass) else $error("load altered");

  property p_pclr_gl;
    op_valid && op_code == TLCF_OP_PCLR && op_mask[`TLCF_P_GL] |=>
      res_valid && !res_cap.perms[`TLCF_P_GL];
  endproperty
  a_pclr_gl: assert property (p_pclr_gl) else $error("scope not cleared");

  property p_deps;
    res_valid && (res_op == TLCF_OP_PCLR && res_cap.otype == '0) |->
      res_cap.perms == tlcf_fix_deps(res_cap.perms);
  endproperty
  a_deps: assert property (p_deps) else $error("orphan permission");

  property p_derive_gl;
    op_valid && (op_code == TLCF_OP_PCLR || op_code == TLCF_OP_SUNSEAL) &&
      !op_data.perms[`TLCF_P_GL] |=> !res_cap.perms[`TLCF_P_GL];
  endproperty
  a_derive_gl: assert property (p_derive_gl) else $error("scope flag raised");

  property p_subset_gl;
    op_valid && op_code == TLCF_OP_SUBSET && op_auth.perms[`TLCF_P_GL] &&
      !op_data.perms[`TLCF_P_GL] |=> res_word == 32'h0;
  endproperty
  a_subset_gl: assert property (p_subset_gl) else $error("bad subset");

  property p_build_gl;
    op_valid && op_code == TLCF_OP_BUILD && op_data.perms[`TLCF_P_GL] &&
      !op_auth.perms[`TLCF_P_GL] |=> !res_cap.tag;
  endproperty
  a_build_gl: assert property (p_build_gl) else $error("build tagged");

  property p_unseal_gl;
    op_valid && op_code == TLCF_OP_SUNSEAL |=> res_cap.perms[`TLCF_P_GL] ==
      ($past(op_auth.perms[`TLCF_P_GL]) && $past(op_data.perms[`TLCF_P_GL]));
  endproperty
  a_unseal_gl: assert property (p_unseal_gl) else $error("unseal scope wrong");

  property p_root;
    op_valid && (op_code == TLCF_OP_ROOTX || op_code == TLCF_OP_ROOTD) |=>
      res_cap.perms[`TLCF_P_GL] && res_cap.perms[`TLCF_P_LG] &&
      (res_op == TLCF_OP_ROOTX || res_cap.perms[`TLCF_P_SL]);
  endproperty
  a_root: assert property (p_root) else $error("root lacks scope");
endmodule // tlcf_top

/* test/tlcf_mem_model.sv */
// one-line capability memory standing behind the store path
// assumes the bench marks which results are stores
`timescale 1ns/1ns
module tlcf_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr,
  input wire tlcf_pkg::tlcf_cap_t wr_cap,
  output tlcf_pkg::tlcf_cap_t rd_cap
);
  import tlcf_pkg::*;
  // ========================================
  // storage
  // keeps the tag exactly as written, so a stripped tag is never repaired
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_cap <= '0;
    end else if (wr) begin
      rd_cap <= wr_cap;
    end
  end
endmodule // tlcf_mem_model

/* test/tb.sv */
// self-checking bench for the capability flow filter top
// assumes the design package, defines header and memory model are compiled
`timescale 1ns/1ns
`include "tlcf_defines.svh"
module tb;
  import tlcf_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic op_valid = 1'b0;
  tlcf_op_t op_code = TLCF_OP_LOAD;
  tlcf_cap_t op_auth = '0;
  tlcf_cap_t op_data = '0;
  logic [`TLCF_PW-1:0] op_mask = 9'h0;
  logic res_valid;
  tlcf_cap_t res_cap;
  logic [31:0] res_word;
  logic is_store = 1'b0;
  tlcf_cap_t mem_cap;
  int fail_count = 0;
  int num_checks = 0;

  // ========================================
  // clock, design and far-side memory
  always #5 clock = ~clock;
  tlcf_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_auth(op_auth), .op_data(op_data), .op_mask(op_mask),
    .res_valid(res_valid), .res_cap(res_cap), .res_word(res_word));
  tlcf_mem_model u_mem (.clock(clock), .rst(rst), .wr(res_valid && is_store),
    .wr_cap(res_cap), .rd_cap(mem_cap));

  // ========================================
  // helpers
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic tlcf_cap_t mk(input logic t, input logic [3:0] ot, input logic [8:0] p);
    return '{t, ot, p, 32'h0000_1000};
  endfunction

  // tagged unsealed and tagged sealed shorthands
  function automatic tlcf_cap_t cu(input logic [8:0] p);
    return mk(1'b1, 4'h0, p);
  endfunction

  function automatic tlcf_cap_t cs(input logic [8:0] p);
    return mk(1'b1, 4'h3, p);
  endfunction

  // one request; the answer stands exactly one cycle after it is taken
  task automatic op(input tlcf_op_t c, input tlcf_cap_t a, input tlcf_cap_t d,
    input logic [8:0] m);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_auth <= a;
    op_data <= d;
    op_mask <= m;
    is_store <= (c == TLCF_OP_STORE);
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk("res_valid", 64'h1, {63'h0, res_valid});
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(what, {32'h0, exp}, {32'h0, reg_rdata});
  endtask

  // ========================================
  // scenarios
  // filtering off must leave a local store whole; unmapped reads give 0
  task automatic t_ctrl();
    reg_check("ctrl reset", `TLCF_REG_CTRL, 32'h1);
    reg_check("unmapped", 4'h2, 32'h0);
    reg_write(`TLCF_REG_CTRL, 32'h0);
    op(TLCF_OP_STORE, cu(9'h007), cu(9'h001), 9'h0);
    chk("store off", cu(9'h001), res_cap);
    reg_write(`TLCF_REG_CTRL, 32'h1);
  endtask

  task automatic t_store();
    op(TLCF_OP_STORE, cu(9'h007), cu(9'h001), 9'h0);
    chk("strip tag", 64'h0, {63'h0, res_cap.tag});
    @(posedge clock);
    #1;
    chk("memory tag", 64'h0, {63'h0, mem_cap.tag});
    op(TLCF_OP_STORE, cu(9'h007), cu(9'h101), 9'h0);
    chk("wide store", cu(9'h101), res_cap);
    op(TLCF_OP_STORE, cu(9'h003), cu(9'h001), 9'h0);
    chk("no transfer", cu(9'h001), res_cap);
    reg_check("strip count", `TLCF_REG_STRIPS, 32'h1);
    reg_write(`TLCF_REG_STRIPS, 32'h0);
    reg_check("strip clear", `TLCF_REG_STRIPS, 32'h0);
  endtask

  task automatic t_load();
    op(TLCF_OP_LOAD, cu(9'h00d), cu(9'h1cf), 9'h0);
    chk("load unsealed", cu(9'h04f), res_cap);
    op(TLCF_OP_LOAD, cu(9'h00d), cs(9'h1cf), 9'h0);
    chk("load sealed", cs(9'h0cf), res_cap);
    op(TLCF_OP_LOAD, cu(9'h001), cu(9'h1cf), 9'h0);
    chk("load no transfer", cu(9'h1cf), res_cap);
    op(TLCF_OP_LOAD, cu(9'h00d), mk(1'b0, 4'h0, 9'h1cf), 9'h0);
    chk("load untagged", mk(1'b0, 4'h0, 9'h1cf), res_cap);
    op(TLCF_OP_LOAD, cu(9'h085), cu(9'h1cf), 9'h0);
    chk("load no mutable", cu(9'h185), res_cap);
    reg_check("atten count", `TLCF_REG_ATTENS, 32'h2);
  endtask

  task automatic t_perms();
    op(TLCF_OP_PCLR, '0, cs(9'h1cf), 9'h101);
    chk("clear sealed", cs(9'h0cf), res_cap);
    op(TLCF_OP_PCLR, '0, cu(9'h1cf), 9'h004);
    chk("clear deps", cu(9'h10b), res_cap);
    op(TLCF_OP_PREAD, '0, cu(9'h1cf), 9'h0);
    chk("perm read", 64'h1cf, {32'h0, res_word});
    reg_check("last op", `TLCF_REG_LASTOP, 32'h4);
  endtask

  task automatic t_derive();
    op(TLCF_OP_SUBSET, cu(9'h1cf), cu(9'h0cf), 9'h0);
    chk("subset local", 64'h0, {32'h0, res_word});
    op(TLCF_OP_SUBSET, cu(9'h1cf), cu(9'h1cf), 9'h0);
    chk("subset wide", 64'h1, {32'h0, res_word});
    op(TLCF_OP_SUBSET, cu(9'h0cf), cu(9'h0cf), 9'h0);
    chk("subset both local", 64'h1, {32'h0, res_word});
    op(TLCF_OP_BUILD, cu(9'h0cf), mk(1'b0, 4'h0, 9'h1cf), 9'h0);
    chk("build raise", 64'h0, {63'h0, res_cap.tag});
    op(TLCF_OP_BUILD, cu(9'h1cf), mk(1'b0, 4'h0, 9'h1cf), 9'h0);
    chk("build wide", 64'h1, {63'h0, res_cap.tag});
    op(TLCF_OP_SUNSEAL, cu(9'h0cf), cs(9'h1cf), 9'h0);
    chk("unseal local", 64'h0, {59'h0, res_cap.otype, res_cap.perms[8]});
    op(TLCF_OP_SUNSEAL, cu(9'h1cf), cs(9'h1cf), 9'h0);
    chk("unseal wide", 64'h1, {59'h0, res_cap.otype, res_cap.perms[8]});
  endtask

  task automatic t_roots();
    op(TLCF_OP_ROOTX, '0, '0, 9'h0);
    chk("root exec", {1'b1, 4'h0, 9'h1bd, 32'h0}, res_cap);
    op(TLCF_OP_ROOTD, '0, '0, 9'h0);
    chk("root data", {1'b1, 4'h0, 9'h1ef, 32'h0}, res_cap);
  endtask

  // a mid-run reset restores the enable and zeroes the atten counter and results
  task automatic t_reset();
    reg_write(`TLCF_REG_CTRL, 32'h0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("reset cap", 64'h0, res_cap);
    chk("reset valid", 64'h0, {63'h0, res_valid});
    reg_check("reset ctrl", `TLCF_REG_CTRL, 32'h1);
    reg_check("reset atten", `TLCF_REG_ATTENS, 32'h0);
  endtask

  // ========================================
  // verdict, watchdog and main sequence
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a hang counts as a mismatch rather than stalling the run
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_ctrl();
    t_store();
    t_load();
    t_perms();
    t_derive();
    t_roots();
    t_reset();
    report_and_stop();
  end
endmodule // tb
